// file: design/cfgm_config_manager.v
`timescale 1ns/1ns
// Summary of operation
// R1: Endpoint answers host discovery at once, before any image load.
// R2: Up to four stored images selectable in configuration flash.
// R3: Power-up image chosen from the board selection switch.
// R4: Host selects image, then reload command reconfigures from that image.
// R5: Host-streamed image configures logic directly, never written to flash; a JTAG write strobe mid-stream still writes the host word to flash.
// R6: JTAG may configure the logic directly, bypassing flash.
// R7: Flash writable through JTAG or through the host link.
// R8: Configuration space kept intact through every reconfiguration.
// R9: Same device identification reported after reload.
// R10: During reload, manager answers config accesses; user traffic held back.
`include "cfgm_map.vh"
module cfgm_config_manager #(
   parameter NUM_IMAGES = `CFGM_NUM_IMAGES,
   parameter ADDR_W     = `CFGM_ADDR_W,
   parameter LOAD_WORDS = 1024
) (
   input  wire                   i_clk,
   input  wire                   i_reset_n,
   input  wire [`CFGM_SEL_W-1:0] i_image_switch,
   input  wire [`CFGM_CMD_W-1:0] i_host_cmd,
   input  wire                   i_host_cmd_valid,
   input  wire [31:0]            i_host_data,
   input  wire                   i_host_data_valid,
   input  wire                   i_cfg_rd,
   input  wire [1:0]             i_cfg_addr,
   input  wire                   i_user_req,
   input  wire                   i_jtag_active,
   input  wire                   i_jtag_flash_wr,
   input  wire [31:0]            i_flash_rdata,
   input  wire                   i_flash_rvalid,
   input  wire                   i_logic_done,
   input  wire                   i_logic_error,
   output reg                    o_ep_ready,
   output reg                    o_cfg_ack,
   output reg  [31:0]            o_cfg_rdata,
   output reg                    o_user_fwd,
   output reg                    o_user_enable,
   output reg                    o_flash_rd,
   output reg  [ADDR_W-1:0]      o_flash_addr,
   output reg                    o_flash_wr,
   output reg  [31:0]            o_flash_wdata,
   output reg                    o_logic_prog_n,
   output reg                    o_logic_wr,
   output reg  [31:0]            o_logic_wdata,
   output reg  [`CFGM_ST_W-1:0]  o_status,
   output reg  [`CFGM_SEL_W-1:0] o_active_image
);

   // ***************************************
   // Input synchronisers
   // ***************************************
   reg [`CFGM_SEL_W-1:0] sw_meta, sw_sync;
   reg                   jtag_meta, jtag_sync;
   reg                   jwr_meta, jwr_sync;
   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         sw_meta   <= 2'h0;
         sw_sync   <= 2'h0;
         jtag_meta <= 1'b0;
         jtag_sync <= 1'b0;
         jwr_meta  <= 1'b0;
         jwr_sync  <= 1'b0;
      end else begin
         sw_meta   <= i_image_switch;
         sw_sync   <= sw_meta;
         jtag_meta <= i_jtag_active;
         jtag_sync <= jtag_meta;
         jwr_meta  <= i_jtag_flash_wr;
         jwr_sync  <= jwr_meta;
      end
   end

   // ***************************************
   // Load sequencer
   // ***************************************
   localparam S_BOOT   = 3'h0;
   localparam S_FLASH  = 3'h1;
   localparam S_STREAM = 3'h2;
   localparam S_JTAG   = 3'h3;
   localparam S_WAIT   = 3'h4;
   localparam S_RUN    = 3'h5;

   function [ADDR_W-1:0] slot_base;
      input [`CFGM_SEL_W-1:0] sel;
      begin
         slot_base = {{(ADDR_W-`CFGM_SEL_W){1'b0}}, sel} << `CFGM_SLOT_SHIFT;
      end
   endfunction

   reg [2:0]             state;
   reg [`CFGM_SEL_W-1:0] pending_image;
   reg [15:0]            word_cnt;
   reg                   boot_armed;
   reg                   boot_ready;
   wire cmd_sel    = i_host_cmd_valid && (i_host_cmd == `CFGM_CMD_SELECT);
   wire cmd_reload = i_host_cmd_valid && (i_host_cmd == `CFGM_CMD_RELOAD);
   wire cmd_stream = i_host_cmd_valid && (i_host_cmd == `CFGM_CMD_STREAM);
   wire cmd_end    = i_host_cmd_valid && (i_host_cmd == `CFGM_CMD_STREAM_END);
   wire cmd_fwr    = i_host_cmd_valid && (i_host_cmd == `CFGM_CMD_FLASH_WR);
   wire idle_ok    = (state == S_RUN) || (state == S_WAIT && o_status == `CFGM_ST_FAIL);

   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state          <= S_BOOT;
         pending_image  <= 2'h0;
         word_cnt       <= 16'h0000;
         boot_armed     <= 1'b0;
         boot_ready     <= 1'b0;
         o_flash_rd     <= 1'b0;
         o_flash_addr   <= {ADDR_W{1'b0}};
         o_logic_prog_n <= 1'b1;
         o_logic_wr     <= 1'b0;
         o_logic_wdata  <= 32'h0000_0000;
         o_status       <= `CFGM_ST_IDLE;
         o_active_image <= 2'h0;
         o_user_enable  <= 1'b0;
      end else begin
         o_logic_wr     <= 1'b0;
         o_logic_prog_n <= 1'b1;
         // R4: image chosen ahead of reload
         if (cmd_sel) begin
            pending_image <= i_host_data[`CFGM_SEL_W-1:0];
         end
         case (state)
            S_BOOT: begin
               // Two edges for the switch to cross its synchroniser
               boot_armed <= 1'b1;
               boot_ready <= boot_armed;
               // R3: switch picks power-up image once synchronised
               if (boot_ready) begin
                  pending_image  <= sw_sync;
                  o_active_image <= sw_sync;
                  o_flash_addr   <= slot_base(sw_sync);
                  o_logic_prog_n <= 1'b0;
                  o_flash_rd     <= 1'b1;
                  word_cnt       <= 16'h0000;
                  o_status       <= `CFGM_ST_BUSY;
                  state          <= S_FLASH;
               end
            end
            // R2: one of four slots streamed from flash
            S_FLASH: begin
               if (i_flash_rvalid) begin
                  o_logic_wr    <= 1'b1;
                  o_logic_wdata <= i_flash_rdata;
                  o_flash_addr  <= o_flash_addr + {{(ADDR_W-1){1'b0}}, 1'b1};
                  word_cnt      <= word_cnt + 16'h0001;
                  if (word_cnt == LOAD_WORDS - 1) begin
                     o_flash_rd <= 1'b0;
                     state      <= S_WAIT;
                  end
               end
            end
            // R5: host words go to logic; flash takes them only if a JTAG write strobe lands mid-stream
            S_STREAM: begin
               if (i_host_data_valid) begin
                  o_logic_wr    <= 1'b1;
                  o_logic_wdata <= i_host_data;
               end
               if (cmd_end) begin
                  state <= S_WAIT;
               end
            end
            // R6: JTAG owns the load; manager only watches
            S_JTAG: begin
               if (!jtag_sync) begin
                  state <= S_WAIT;
               end
            end
            S_WAIT: begin
               if (i_logic_done) begin
                  o_status      <= `CFGM_ST_DONE;
                  o_user_enable <= 1'b1;
                  state         <= S_RUN;
               end else if (i_logic_error) begin
                  o_status <= `CFGM_ST_FAIL;
               end
            end
            default: begin
               state <= S_RUN;
            end
         endcase
         // Restart requests accepted only when no load is in flight
         if (idle_ok && jtag_sync) begin
            o_user_enable  <= 1'b0;
            o_status       <= `CFGM_ST_BUSY;
            state          <= S_JTAG;
         end else if (idle_ok && cmd_reload) begin
            // R4: reload from selected alternate image
            o_user_enable  <= 1'b0;
            o_active_image <= pending_image;
            o_flash_addr   <= slot_base(pending_image);
            o_flash_rd     <= 1'b1;
            o_logic_prog_n <= 1'b0;
            word_cnt       <= 16'h0000;
            o_status       <= `CFGM_ST_BUSY;
            state          <= S_FLASH;
         end else if (idle_ok && cmd_stream) begin
            o_user_enable  <= 1'b0;
            o_logic_prog_n <= 1'b0;
            o_status       <= `CFGM_ST_BUSY;
            state          <= S_STREAM;
         end
      end
   end

   // ***************************************
   // Flash programming path
   // ***************************************
   // R7: host data written to flash on host command or JTAG write strobe
   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_flash_wr    <= 1'b0;
         o_flash_wdata <= 32'h0000_0000;
      end else begin
         o_flash_wr    <= (cmd_fwr && state == S_RUN) || jwr_sync;
         o_flash_wdata <= i_host_data;
      end
   end

   // ***************************************
   // Endpoint and configuration space
   // ***************************************
   wire [31:0] id_word;
   cfgm_id_rom #(
      .DEPTH_W (2)
   ) u_id_rom (
      .i_clk     (i_clk),
      .i_reset_n (i_reset_n),
      .i_addr    (i_cfg_addr),
      .o_data    (id_word)
   );

   reg rd_pend;
   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_ep_ready  <= 1'b0;
         rd_pend     <= 1'b0;
         o_cfg_ack   <= 1'b0;
         o_cfg_rdata <= 32'h0000_0000;
         o_user_fwd  <= 1'b0;
      end else begin
         // R1: endpoint live one cycle after reset, no image wait
         o_ep_ready  <= 1'b1;
         rd_pend     <= i_cfg_rd;
         // R8: config space served here, untouched by reloads
         // R10: answered even mid-reload
         o_cfg_ack   <= rd_pend;
         // R9: identity from constant store
         o_cfg_rdata <= rd_pend ? id_word : 32'h0000_0000;
         // R10: user traffic gated until load succeeds
         o_user_fwd  <= i_user_req && o_user_enable;
      end
   end
endmodule // cfgm_config_manager

// file: design/cfgm_map.vh
`ifndef CFGM_MAP_VH
`define CFGM_MAP_VH
// Image slots and select width
`define CFGM_NUM_IMAGES     4
`define CFGM_SEL_W          2
// Flash read address width and image slot size (log2 words)
`define CFGM_ADDR_W         24
`define CFGM_SLOT_SHIFT     22
// Host command codes
`define CFGM_CMD_W          3
`define CFGM_CMD_NONE       3'h0
`define CFGM_CMD_SELECT     3'h1
`define CFGM_CMD_RELOAD     3'h2
`define CFGM_CMD_STREAM     3'h3
`define CFGM_CMD_STREAM_END 3'h4
`define CFGM_CMD_FLASH_WR   3'h5
// Status codes
`define CFGM_ST_W           2
`define CFGM_ST_IDLE        2'h0
`define CFGM_ST_BUSY        2'h1
`define CFGM_ST_DONE        2'h2
`define CFGM_ST_FAIL        2'h3
// Host discovery window and derived endpoint-ready budget
`define CFGM_DISCOVERY_MS   100
`define CFGM_CLK_KHZ        25000
`define CFGM_EP_READY_CYC   (`CFGM_DISCOVERY_MS * `CFGM_CLK_KHZ)
// Identity reset values, arbitrary
`define CFGM_VENDOR_ID      16'h1AB5
`define CFGM_DEVICE_ID      16'h00C3
`endif

// file: design/cfgm_id_rom.v
`timescale 1ns/1ns
// ***************************************
// Configuration identity store
// ***************************************
module cfgm_id_rom #(
   parameter DEPTH_W = 2
) (
   input  wire               i_clk,
   input  wire               i_reset_n,
   input  wire [DEPTH_W-1:0] i_addr,
   output reg  [31:0]        o_data
);
`include "cfgm_map.vh"
   // Constant contents, so no reload path can reach them
   function [31:0] id_at;
      input [DEPTH_W-1:0] addr;
      begin
         if (addr == {DEPTH_W{1'b0}}) begin
            id_at = {`CFGM_DEVICE_ID, `CFGM_VENDOR_ID};
         end else begin
            id_at = 32'h0000_0000;
         end
      end
   endfunction

   // Registered read so reload never disturbs identity
   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_data <= 32'h0000_0000;
      end else begin
         o_data <= id_at(i_addr);
      end
   end
endmodule // cfgm_id_rom

// file: test/cfgm_monitor.sv
`timescale 1ns/1ns
`include "cfgm_map.vh"
// ****
// Checker
// ****
module cfgm_monitor (
   input wire        i_clk,
   input wire        i_reset_n,
   input wire        i_cfg_rd,
   input wire [1:0]  i_cfg_addr,
   input wire [2:0]  i_host_cmd,
   input wire        i_host_cmd_valid,
   input wire [31:0] i_host_data,
   input wire        i_host_data_valid,
   input wire        i_user_req,
   input wire        i_jtag_active,
   input wire        o_ep_ready,
   input wire        o_cfg_ack,
   input wire [31:0] o_cfg_rdata,
   input wire        o_user_fwd,
   input wire        o_user_enable,
   input wire        o_flash_rd,
   input wire        o_logic_prog_n,
   input wire        o_logic_wr,
   input wire [31:0] o_logic_wdata,
   input wire [1:0]  o_status
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);
   a_ep_ready_held: assert property ($past(i_reset_n) |-> o_ep_ready)
      else $error("endpoint dropped");
   a_cfg_ack_two: assert property (i_cfg_rd |-> ##2 o_cfg_ack)
      else $error("config ack late");
   a_cfg_id_kept: assert property (o_cfg_ack && $past(i_cfg_addr, 2) == 2'h0 |->
      o_cfg_rdata == {`CFGM_DEVICE_ID, `CFGM_VENDOR_ID}) else $error("identity changed");
   a_user_fwd_gated: assert property (o_user_fwd |-> $past(i_user_req && o_user_enable))
      else $error("user forward ungated");
   a_busy_no_user: assert property ((o_status == `CFGM_ST_BUSY) [*2] |-> !o_user_enable)
      else $error("user enabled while busy");
   a_stream_word: assert property (i_host_data_valid && o_status == `CFGM_ST_BUSY |=>
      o_logic_wr && o_logic_wdata == $past(i_host_data)) else $error("stream word lost");
   a_prog_pulse: assert property ($fell(o_logic_prog_n) |=> o_logic_prog_n)
      else $error("program pulse too long");
   a_reload_start: assert property (i_host_cmd_valid && i_host_cmd == `CFGM_CMD_RELOAD &&
      o_status[1] && !i_jtag_active |=> !o_logic_prog_n && o_flash_rd) else $error("reload ignored");
   c_cfg_read: cover property (o_cfg_ack);
   c_load: cover property ($fell(o_logic_prog_n));
   c_fail: cover property (o_status == `CFGM_ST_FAIL);
endmodule // cfgm_monitor

// file: test/cfgm_far_model.sv
`timescale 1ns/1ns
// ****
// Flash and logic model
// ****
module cfgm_far_model #(
   parameter WORDS = 8
) (
   input  wire        i_clk,
   input  wire        i_bad,
   input  wire        i_fast,
   input  wire        i_rd,
   input  wire [23:0] i_addr,
   input  wire        i_prog_n,
   input  wire        i_wr,
   output wire [31:0] o_rdata,
   output reg         o_rvalid = 1'h0,
   output reg         o_done = 1'h0,
   output reg         o_err = 1'h0
);
   reg [7:0] cnt = 8'h00;
   // Slow mode answers every other cycle
   always @(posedge i_clk) begin
      o_rvalid <= i_rd & i_prog_n & (i_fast | ~o_rvalid);
      if (!i_prog_n) begin
         cnt <= 8'h00;
         o_done <= 1'h0;
         o_err <= 1'h0;
      end else if (i_wr)
         cnt <= cnt + 8'h01;
      if (i_prog_n && cnt == WORDS) begin
         o_done <= !i_bad;
         o_err <= i_bad;
      end
   end
   // Bus not valid shows inverted data, never stale
   assign o_rdata = o_rvalid ? {8'h5A, i_addr} : ~{8'h5A, i_addr};
endmodule // cfgm_far_model

// file: test/cfgm_config_manager_bench.sv
`timescale 1ns/1ns
`include "cfgm_map.vh"
module cfgm_config_manager_bench;
   localparam [31:0] ID = {`CFGM_DEVICE_ID, `CFGM_VENDOR_ID};
   logic        i_clk = 1'h0, i_reset_n = 1'h0, i_host_cmd_valid = 1'h0, i_host_data_valid = 1'h0;
   logic        i_cfg_rd = 1'h0, i_user_req = 1'h1, i_jtag_active = 1'h0, i_jtag_flash_wr = 1'h0;
   logic        bad = 1'h0, fast = 1'h0;
   logic [1:0]  i_image_switch = 2'h2, i_cfg_addr = 2'h0;
   logic [2:0]  i_host_cmd = 3'h0;
   logic [31:0] i_host_data = 32'h0;
   wire  [31:0] i_flash_rdata, o_cfg_rdata, o_flash_wdata, o_logic_wdata;
   wire         i_flash_rvalid, i_logic_done, i_logic_error, o_ep_ready, o_cfg_ack, o_user_fwd;
   wire         o_user_enable, o_flash_rd, o_flash_wr, o_logic_prog_n, o_logic_wr;
   wire  [23:0] o_flash_addr;
   wire  [1:0]  o_status, o_active_image;
   int          miscompares = 0, checked = 0, nflash = 0;
   always #20 i_clk = ~i_clk;
   always @(posedge i_clk) if (o_flash_wr === 1'h1) nflash++;
   // Short load keeps the run brief
   cfgm_config_manager #(.LOAD_WORDS(8)) dut (.*);
   cfgm_far_model #(.WORDS(8)) far (.i_clk(i_clk), .i_bad(bad), .i_fast(fast), .i_rd(o_flash_rd),
      .i_addr(o_flash_addr), .i_prog_n(o_logic_prog_n), .i_wr(o_logic_wr), .o_rdata(i_flash_rdata),
      .o_rvalid(i_flash_rvalid), .o_done(i_logic_done), .o_err(i_logic_error));
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk);
   endtask
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic cmd(input logic [2:0] c, input logic [31:0] d);
      i_host_cmd <= c;
      i_host_data <= d;
      i_host_cmd_valid <= 1'h1;
      tick(1);
      i_host_cmd_valid <= 1'h0;
      tick(1);
   endtask
   task automatic cfg(input logic [1:0] a, input logic [31:0] exp);
      i_cfg_rd <= 1'h1;
      i_cfg_addr <= a;
      tick(1);
      i_cfg_rd <= 1'h0;
      tick(2);
      chk("cfg ack", o_cfg_ack, 32'h1);
      chk("cfg data", o_cfg_rdata, exp);
   endtask
   task automatic wait_st(input logic [1:0] st);
      int n = 0;
      while (o_status !== st && n < 300) begin
         tick(1);
         n++;
      end
      chk("status", o_status, st);
   endtask
   task automatic t_boot;
      int n = 0;
      tick(2);
      chk("ep ready", o_ep_ready, 32'h1);
      while (o_flash_rd !== 1'h1 && n < 20) begin
         tick(1);
         n++;
      end
      chk("boot rd", o_flash_rd, 32'h1);
      chk("boot slot", o_flash_addr, {i_image_switch, 22'h0});
      cfg(2'h1, 32'h0);
      chk("user held", o_user_fwd, 32'h0);
      wait_st(`CFGM_ST_DONE);
      tick(2);
      chk("user fwd", o_user_fwd, 32'h1);
   endtask
   task automatic t_reload;
      for (int i = 0; i < 4; i++) begin
         fast <= i[0];
         cmd(`CFGM_CMD_SELECT, i);
         cmd(`CFGM_CMD_RELOAD, 32'h0);
         chk("prog pulse", o_logic_prog_n, 32'h0);
         chk("slot addr", o_flash_addr, i << 22);
         cfg(2'h0, ID);
         wait_st(`CFGM_ST_DONE);
         chk("image", o_active_image, i);
         cfg(2'h0, ID);
      end
   endtask
   task automatic t_stream;
      nflash = 0;
      cmd(`CFGM_CMD_STREAM, 32'h0);
      for (int i = 0; i < 8; i++) begin
         i_host_data <= 32'hC0DE0000 + i;
         i_host_data_valid <= 1'h1;
         tick(1);
         i_host_data_valid <= 1'h0;
         tick(1);
         chk("stream wr", o_logic_wr, 32'h1);
         chk("stream word", o_logic_wdata, 32'hC0DE0000 + i);
      end
      cmd(`CFGM_CMD_STREAM_END, 32'h0);
      wait_st(`CFGM_ST_DONE);
      chk("no flash copy", nflash, 32'h0);
   endtask
   task automatic t_jtag;
      cmd(`CFGM_CMD_FLASH_WR, 32'hA5C30F1E);
      chk("host flash wr", o_flash_wr, 32'h1);
      chk("flash data", o_flash_wdata, 32'hA5C30F1E);
      i_jtag_active <= 1'h1;
      i_jtag_flash_wr <= 1'h1;
      tick(1);
      // Host write already counted; clear once its strobe has gone
      nflash = 0;
      i_jtag_flash_wr <= 1'h0;
      tick(6);
      chk("jtag flash wr", nflash, 32'h1);
      chk("jtag busy", o_status, `CFGM_ST_BUSY);
      chk("user held", o_user_fwd, 32'h0);
      cfg(2'h0, ID);
      i_jtag_active <= 1'h0;
      wait_st(`CFGM_ST_DONE);
   endtask
   task automatic t_fail;
      bad <= 1'h1;
      cmd(`CFGM_CMD_RELOAD, 32'h0);
      wait_st(`CFGM_ST_FAIL);
      chk("user off", o_user_enable, 32'h0);
      bad <= 1'h0;
      cmd(`CFGM_CMD_RELOAD, 32'h0);
      wait_st(`CFGM_ST_DONE);
      chk("user back", o_user_enable, 32'h1);
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial begin
      tick(10);
      i_reset_n <= 1'h1;
      t_boot;
      t_reload;
      t_stream;
      t_jtag;
      t_fail;
      report_and_stop;
   end
   // Whole run needs a few hundred cycles
   initial begin
      #400000;
      miscompares++;
      report_and_stop;
   end
endmodule // cfgm_config_manager_bench
bind cfgm_config_manager cfgm_monitor mon (.*);
